//--- src/pilot_ignition_sequencer.sv
// Summary of operation
// [R1] Prepurge variants wait 45 seconds after call for heat before trial.
// [R2] Blower and airflow switch must precede the call; external party duty.
// [R3] Trial start opens pilot valve and enables spark together.
// [R4] Main valve stays closed until flame current is proven and stable.
// [R5] Continuous variant sparks while call persists or until flame, untimed.
// [R6] Lockout and retry variants time the trial; spark stops at expiry.
// [R7] Lockout closes pilot valve and holds it closed until valid reset.
// [R8] Lockout clears only after call absent or power removed one minute; here any RESET clears it at once.
// [R9] Retry variant waits six minutes after shutoff, never under five.
// [R10] Retry cycle repeats until flame or call withdrawn; one-minute removal resets.
// [R11] Retry variant trial ends in shutoff within 90 seconds without flame.
// [R12] Detected flame disables spark and opens main valve.
// [R13] Flame holds the lockout timer in reset while present.
// [R14] Call withdrawal closes both valves and returns to idle.
// [R15] Inputs synchronised; all timers run from a prescaled clock counter.
`timescale 1ns/1ns
`default_nettype none

module pilot_ignition_sequencer #(
    parameter int PRESCALE = ign_pkg::PRESCALE_DEFAULT,
    parameter ign_pkg::fail_mode_t FAIL_MODE = ign_pkg::FAIL_LOCKOUT,
    parameter bit HAS_PREPURGE = 1'b1
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HEAT_CALL,
    input wire logic FLAME_SENSE,
    output logic PILOT_VALVE,
    output logic MAIN_VALVE,
    output logic SPARK,
    output logic LOCKED_OUT
);

    // ********************************************************
    // Types and declarations
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PREPURGE = 3'h1,
        ST_TRIAL = 3'h2,
        ST_RUN = 3'h3,
        ST_LOCKOUT = 3'h4,
        ST_RETRY_WAIT = 3'h5
    } state_t;

    localparam int PRE_W = $clog2(PRESCALE + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
    localparam logic [ign_pkg::SEC_W-1:0] PREPURGE_T = ign_pkg::SEC_W'(ign_pkg::PREPURGE_SEC);
    localparam logic [ign_pkg::SEC_W-1:0] TRIAL_T = ign_pkg::SEC_W'(ign_pkg::TRIAL_SEC);
    localparam logic [ign_pkg::SEC_W-1:0] WAIT_T = ign_pkg::SEC_W'(ign_pkg::RETRY_WAIT_SEC);
    localparam logic [ign_pkg::SEC_W-1:0] HOLD_T = ign_pkg::SEC_W'(ign_pkg::RESET_HOLD_SEC);
    localparam logic [1:0] STABLE_T = 2'(ign_pkg::FLAME_STABLE_TICKS);

    ign_pkg::sensed_in_t raw_in;
    ign_pkg::sensed_in_t sync_in;
    state_t state;
    state_t next_state;
    logic [PRE_W-1:0] prescale_cnt;
    logic tick;
    logic [ign_pkg::SEC_W-1:0] phase_sec;
    logic [ign_pkg::SEC_W-1:0] off_sec;
    logic [1:0] stable_cnt;
    logic flame_ok;
    logic call_gone_minute;
    ign_pkg::valve_out_t next_out;

    // ********************************************************
    // Input synchronisation
    // ********************************************************
    assign raw_in.heat_call = HEAT_CALL;
    assign raw_in.flame = FLAME_SENSE;

    ign_sync u_sync (
        .clk(CLK),
        .reset(RESET),
        .raw(raw_in),
        .synced(sync_in)
    ); // [R15]

    // ********************************************************
    // Timebase
    // ********************************************************
    // Prescaler yields a one-cycle tick per timer unit
    always_ff @(posedge CLK) begin
        if (RESET || prescale_cnt == PRE_LAST) begin
            prescale_cnt <= '0;
        end else begin
            prescale_cnt <= prescale_cnt + 1'b1;
        end
    end

    assign tick = (prescale_cnt == PRE_LAST); // [R15]

    // Phase timer restarts on every state change; flame in the trial holds it at zero
    always_ff @(posedge CLK) begin
        if (RESET || next_state != state) begin
            phase_sec <= '0;
        end else if (state == ST_TRIAL && sync_in.flame) begin
            phase_sec <= '0; // [R13]
        end else if (tick && phase_sec != '1) begin
            phase_sec <= phase_sec + 1'b1; // [R15]
        end
    end

    // Call-absent timer; power loss is RESET, which also clears lockout
    always_ff @(posedge CLK) begin
        if (RESET || sync_in.heat_call) begin
            off_sec <= '0;
        end else if (tick && off_sec != HOLD_T) begin
            off_sec <= off_sec + 1'b1;
        end
    end

    assign call_gone_minute = (off_sec == HOLD_T); // [R8]

    // Flame must be present for a few ticks before it counts as steady
    always_ff @(posedge CLK) begin
        if (RESET || !sync_in.flame) begin
            stable_cnt <= '0;
        end else if (tick && stable_cnt != STABLE_T) begin
            stable_cnt <= stable_cnt + 1'b1;
        end
    end

    assign flame_ok = (stable_cnt == STABLE_T); // [R4]

    // ********************************************************
    // Sequencer
    // ********************************************************
    // Trial timer restarts on entry to the trial, flame in the trial holds it at zero
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sync_in.heat_call) begin
                    next_state = HAS_PREPURGE ? ST_PREPURGE : ST_TRIAL; // [R1] [R3]
                end
            end
            ST_PREPURGE: begin
                if (!sync_in.heat_call) begin
                    next_state = ST_IDLE; // [R14]
                end else if (tick && phase_sec == PREPURGE_T - 1'b1) begin
                    next_state = ST_TRIAL; // [R1]
                end
            end
            ST_TRIAL: begin
                if (!sync_in.heat_call) begin
                    next_state = ST_IDLE; // [R14]
                end else if (flame_ok) begin
                    next_state = ST_RUN; // [R12] [R13]
                end else if (FAIL_MODE != ign_pkg::FAIL_CONTINUOUS
                             && tick && phase_sec == TRIAL_T - 1'b1) begin
                    // Untimed variant never times out; it leaves only for flame or call removal
                    next_state = (FAIL_MODE == ign_pkg::FAIL_RETRY)
                                 ? ST_RETRY_WAIT : ST_LOCKOUT; // [R6] [R11] [R5]
                end
            end
            ST_RUN: begin
                if (!sync_in.heat_call) begin
                    next_state = ST_IDLE; // [R14]
                end else if (!sync_in.flame) begin
                    // Flame loss restarts a fresh trial rather than opening blind
                    next_state = ST_TRIAL;
                end
            end
            ST_LOCKOUT: begin
                if (call_gone_minute) begin
                    next_state = ST_IDLE; // [R7] [R8]
                end
            end
            ST_RETRY_WAIT: begin
                if (call_gone_minute) begin
                    next_state = ST_IDLE; // [R10]
                end else if (tick && phase_sec == WAIT_T - 1'b1) begin
                    next_state = sync_in.heat_call ? ST_TRIAL : ST_IDLE; // [R9] [R10]
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************
    // Outputs, registered from the next state
    // ********************************************************
    // Decoding from next_state keeps outputs glitch free and aligned with state
    always_comb begin
        next_out = '0;
        case (next_state)
            ST_TRIAL: begin
                next_out.pilot_valve = 1'b1; // [R3]
                next_out.spark = 1'b1;       // [R3] [R5] [R6]
            end
            ST_RUN: begin
                next_out.pilot_valve = 1'b1;
                next_out.main_valve = 1'b1;  // [R4] [R12]
            end
            default: begin
                next_out = '0;               // [R7] [R14]
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            PILOT_VALVE <= 1'b0;
            MAIN_VALVE <= 1'b0;
            SPARK <= 1'b0;
            LOCKED_OUT <= 1'b0;
        end else begin
            PILOT_VALVE <= next_out.pilot_valve;
            MAIN_VALVE <= next_out.main_valve;
            SPARK <= next_out.spark;
            LOCKED_OUT <= (next_state == ST_LOCKOUT); // [R7]
        end
    end

endmodule

`default_nettype wire

//--- src/ign_pkg.sv
package ign_pkg;

    // ********************************************************
    // Variants
    // ********************************************************
    typedef enum logic [1:0] {
        FAIL_CONTINUOUS = 2'h0,
        FAIL_LOCKOUT = 2'h1,
        FAIL_RETRY = 2'h2
    } fail_mode_t;

    // ********************************************************
    // Timing, in seconds, and the derived tick rate
    // ********************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int PRESCALE_DEFAULT = CLK_HZ; // One tick per second
    localparam int PREPURGE_SEC = 45;
    localparam int TRIAL_SEC = 90;
    localparam int RETRY_WAIT_SEC = 360;      // Six minutes nominal, above five minimum
    localparam int RESET_HOLD_SEC = 60;
    localparam int FLAME_STABLE_TICKS = 2;
    localparam int SEC_W = 9;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic pilot_valve;
        logic main_valve;
        logic spark;
    } valve_out_t;

    typedef struct packed {
        logic heat_call;
        logic flame;
    } sensed_in_t;

endpackage

//--- src/ign_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ign_sync (
    input wire logic clk,
    input wire logic reset,
    input wire ign_pkg::sensed_in_t raw,
    output ign_pkg::sensed_in_t synced
);

    // ********************************************************
    // Two-stage synchroniser per input bit
    // ********************************************************
    ign_pkg::sensed_in_t stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= raw;
            synced <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- verification/ign_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Sequencer safety checks
// ****
module ign_monitor #(
    parameter int PRESCALE = 10,
    parameter ign_pkg::fail_mode_t FAIL_MODE = ign_pkg::FAIL_LOCKOUT,
    parameter bit HAS_PREPURGE = 1'b1
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HEAT_CALL,
    input wire logic FLAME_SENSE,
    input wire logic PILOT_VALVE,
    input wire logic MAIN_VALVE,
    input wire logic SPARK,
    input wire logic LOCKED_OUT
);
    int call_cnt;
    int off_cnt;
    int spark_cnt;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Run lengths; long timers are too big for repetition operators
    always_ff @(posedge CLK) begin
        call_cnt <= (RESET || !HEAT_CALL) ? 0 : call_cnt + 1;
        off_cnt <= (RESET || HEAT_CALL) ? 0 : off_cnt + 1;
        spark_cnt <= (RESET || !SPARK) ? 0 : spark_cnt + 1;
    end
    AST_MAIN_NEEDS_PILOT: assert property (MAIN_VALVE |-> PILOT_VALVE)
        else $error("main valve open with pilot closed");
    // Four back covers two sync stages, the proving edge and the output register
    AST_MAIN_NEEDS_FLAME: assert property ($rose(MAIN_VALVE) |-> $past(FLAME_SENSE, 4))
        else $error("main valve opened without flame");
    AST_NO_SPARK_IN_RUN: assert property (MAIN_VALVE |-> !SPARK)
        else $error("spark active with main valve open");
    AST_TRIAL_TOGETHER: assert property ($rose(PILOT_VALVE) |-> SPARK)
        else $error("pilot opened without spark");
    AST_PREPURGE: assert property (
        $rose(PILOT_VALVE) && HAS_PREPURGE |-> call_cnt >= 44 * PRESCALE)
        else $error("trial began before prepurge ended");
    AST_TRIAL_LIMIT: assert property (
        FAIL_MODE != ign_pkg::FAIL_CONTINUOUS |-> spark_cnt <= 90 * PRESCALE + 2)
        else $error("spark longer than trial time");
    AST_LOCK_CLOSES: assert property (
        LOCKED_OUT |-> !PILOT_VALVE && !MAIN_VALVE && !SPARK)
        else $error("output active in lockout");
    AST_LOCK_FROM_TRIAL: assert property (
        $rose(LOCKED_OUT) |-> $past(SPARK) && !$past(MAIN_VALVE))
        else $error("lockout entered outside trial");
    // Power loss also clears lockout, so a fall straight after reset is exempt
    AST_LOCK_CLEAR: assert property (
        $fell(LOCKED_OUT) && !$past(RESET) |-> off_cnt >= 59 * PRESCALE)
        else $error("lockout cleared too early");
    AST_CALL_DROP: assert property (
        !HEAT_CALL [*4] |-> !PILOT_VALVE && !MAIN_VALVE && !SPARK)
        else $error("outputs stay on after call removed");
    // Untimed variant drops spark only for proven flame or a removed call
    AST_CONT_SPARK: assert property (
        $fell(SPARK) && FAIL_MODE == ign_pkg::FAIL_CONTINUOUS |-> MAIN_VALVE || call_cnt == 0)
        else $error("untimed spark stopped without flame or call removal");
endmodule
`default_nettype wire

//--- verification/ign_flame_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Pilot burner and flame sensor
// ****
module ign_flame_model (
    input wire logic clk,
    input wire logic gas_on,
    input wire logic pilot_valve,
    input wire logic spark,
    output logic flame
);
    initial flame = 1'b0;
    // Lights only with gas, pilot valve and spark; dies at once without gas
    // Changes on the falling edge, like every other bench input
    always @(negedge clk) begin
        if (!gas_on || !pilot_valve) begin
            flame <= 1'b0;
        end else if (spark) begin
            flame <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Sequencer bench
// ****
module tb_top;
    localparam int P = 10;
    localparam int I_CONT = 0;
    localparam int I_LOCK = 1;
    localparam int I_RETRY = 2;
    logic clk;
    logic rst;
    logic [2:0] call;
    logic [2:0] gas;
    wire logic [2:0] flame;
    wire logic [2:0] pilot;
    wire logic [2:0] main_v;
    wire logic [2:0] spark;
    wire logic [2:0] locked;
    wire logic [2:0][3:0] outs;
    int error_cnt = 0;
    int n_checks = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One sequencer per failure variant; the index is the variant's encoding
    for (genvar g = 0; g < 3; g++) begin : g_var
        assign outs[g] = {pilot[g], main_v[g], spark[g], locked[g]};
        pilot_ignition_sequencer #(
            .PRESCALE(P),
            .FAIL_MODE(ign_pkg::fail_mode_t'(2'(g))),
            .HAS_PREPURGE(g == I_LOCK)
        ) pilot_ignition_sequencer_inst (
            .CLK(clk),
            .RESET(rst),
            .HEAT_CALL(call[g]),
            .FLAME_SENSE(flame[g]),
            .PILOT_VALVE(pilot[g]),
            .MAIN_VALVE(main_v[g]),
            .SPARK(spark[g]),
            .LOCKED_OUT(locked[g])
        );
        ign_flame_model ign_flame_model_inst (
            .clk(clk),
            .gas_on(gas[g]),
            .pilot_valve(pilot[g]),
            .spark(spark[g]),
            .flame(flame[g])
        );
    end
    // Shared helpers; outputs compared as one four-bit word per variant
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_out(input int k, input logic [3:0] exp, input int lim);
        for (int i = 0; i < lim && outs[k] !== exp; i++) cyc(1);
        chk(outs[k], exp);
    endtask
    // No gas: trial times out into lockout, held until call is gone a minute
    task automatic t_lockout();
        gas[I_LOCK] = 1'b0;
        call[I_LOCK] = 1'b1;
        cyc(44 * P);
        chk(outs[I_LOCK], 4'h0);
        wait_out(I_LOCK, 4'ha, 2 * P + 4);
        cyc(88 * P);
        chk(outs[I_LOCK], 4'ha);
        wait_out(I_LOCK, 4'h1, 3 * P);
        cyc(100 * P);
        chk(outs[I_LOCK], 4'h1);
        call[I_LOCK] = 1'b0;
        cyc(57 * P);
        chk(outs[I_LOCK], 4'h1);
        wait_out(I_LOCK, 4'h0, 4 * P);
    endtask
    // Second lockout, then a short power loss clears it; others are idle here
    task automatic t_power();
        call[I_LOCK] = 1'b1;
        wait_out(I_LOCK, 4'h1, 140 * P);
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        chk(outs[I_LOCK], 4'h0);
        cyc(2);
        chk(outs[I_LOCK], 4'h0);
        call[I_LOCK] = 1'b0;
        cyc(4);
        chk(outs[I_LOCK], 4'h0);
    endtask
    // Gas on: flame proven, run past the trial time, then call withdrawn
    task automatic t_run();
        gas[I_LOCK] = 1'b1;
        call[I_LOCK] = 1'b1;
        wait_out(I_LOCK, 4'ha, 46 * P);
        wait_out(I_LOCK, 4'hc, 5 * P);
        cyc(120 * P);
        chk(outs[I_LOCK], 4'hc);
        call[I_LOCK] = 1'b0;
        cyc(1);
        chk(outs[I_LOCK], 4'hc);
        wait_out(I_LOCK, 4'h0, 4);
        gas[I_LOCK] = 1'b0;
    endtask
    // Retry variant: failed trial, five-to-six minute wait, lit on the retry
    task automatic t_retry();
        gas[I_RETRY] = 1'b0;
        call[I_RETRY] = 1'b1;
        wait_out(I_RETRY, 4'ha, 5);
        cyc(88 * P);
        chk(outs[I_RETRY], 4'ha);
        wait_out(I_RETRY, 4'h0, 3 * P);
        cyc(300 * P);
        chk(outs[I_RETRY], 4'h0);
        wait_out(I_RETRY, 4'ha, 62 * P);
        gas[I_RETRY] = 1'b1;
        wait_out(I_RETRY, 4'hc, 5 * P);
        call[I_RETRY] = 1'b0;
        wait_out(I_RETRY, 4'h0, 4);
        gas[I_RETRY] = 1'b0;
    endtask
    // Untimed variant: sparks past the trial time until call removal or flame
    task automatic t_cont();
        gas[I_CONT] = 1'b0;
        call[I_CONT] = 1'b1;
        wait_out(I_CONT, 4'ha, 5);
        cyc(120 * P);
        chk(outs[I_CONT], 4'ha);
        call[I_CONT] = 1'b0;
        wait_out(I_CONT, 4'h0, 4);
        call[I_CONT] = 1'b1;
        wait_out(I_CONT, 4'ha, 5);
        gas[I_CONT] = 1'b1;
        wait_out(I_CONT, 4'hc, 5 * P);
        call[I_CONT] = 1'b0;
        wait_out(I_CONT, 4'h0, 4);
        gas[I_CONT] = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Tests take about 12000 cycles; twice that means a hang
    initial begin
        #(2500 * P * 10);
        error_cnt++;
        report_and_stop();
    end
    // Scenarios run one after another; the power loss resets all variants
    initial begin
        rst = 1'b1;
        call = '0;
        gas = '0;
        cyc(3);
        rst = 1'b0;
        t_lockout();
        t_power();
        t_run();
        t_retry();
        t_cont();
        report_and_stop();
    end
endmodule
bind pilot_ignition_sequencer ign_monitor #(
    .PRESCALE(PRESCALE),
    .FAIL_MODE(FAIL_MODE),
    .HAS_PREPURGE(HAS_PREPURGE)
) ign_monitor_inst (
    .CLK(CLK),
    .RESET(RESET),
    .HEAT_CALL(HEAT_CALL),
    .FLAME_SENSE(FLAME_SENSE),
    .PILOT_VALVE(PILOT_VALVE),
    .MAIN_VALVE(MAIN_VALVE),
    .SPARK(SPARK),
    .LOCKED_OUT(LOCKED_OUT)
);
`default_nettype wire
